// ==== rtl/rlpc_ctrl.sv ====
`timescale 1ns/1ps
`include "rlpc_regs.svh"

module rlpc_ctrl #(
	parameter int FAST_DIV = `RLPC_FAST_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// register bus
	input wire logic [7:0] busAddr,
	input wire logic [7:0] busWdata,
	input wire logic busWr,
	input wire logic busRd,
	output logic [7:0] busRdata,
	// tick sources and detector, from other clocks
	input wire logic slowOscClk,
	input wire logic fastOscClk,
	input wire logic lowVoltTrip,
	input wire logic stopMode,
	// outside module flags and enables, same clock
	input wire rlpc_pkg::rlpc_src_t keypadSrc,
	input wire rlpc_pkg::rlpc_src_t comparatorSrc,
	input wire rlpc_pkg::rlpc_src_t timerSrc,
	// system outputs
	output logic wakeupIrq,
	output logic lowVoltIrq,
	output logic lowVoltReset,
	output logic lowVoltDetectOn,
	output logic slowOscPowerDown,
	output logic bandgapBufferEnable,
	output logic [7:0] pendingSummary
);
	rlpc_pkg::rlpc_bus_t bus;
	logic slowTick;
	logic fastTick;
	logic lowVoltSync;
	logic timeout;
	// wakeup register state
	logic wakeFlag_reg;
	logic wakeClkSel_reg;
	logic wakeIe_reg;
	logic [2:0] wakePeriod_reg;
	// power register state
	logic lvFlag_reg;
	logic lvIe_reg;
	logic lvRe_reg;
	logic lvSe_reg;
	logic lvLe_reg;
	logic bandgap_buffer_enable_reg;
	logic lvOnceDone_reg;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	// decode
	logic selRti;
	logic selPwr;
	logic selPend;
	logic wrRti;
	logic wrPwr;
	logic wakeAck;
	logic lvAck;
	logic lvDetect;
	logic [7:0] rtiView;
	logic [7:0] pwrView;
	logic [7:0] pendView;

	assign bus = '{addr: busAddr, wdata: busWdata, wr: busWr, rd: busRd};

	// oscillator and detector inputs pass two flops before any logic; stopMode is used directly
	rlpc_sync u_slowSync (
		.clk(clk),
		.reset(reset),
		.asyncIn(slowOscClk),
		.syncOut(),
		.risePulse(slowTick)
	);
	rlpc_sync u_fastSync (
		.clk(clk),
		.reset(reset),
		.asyncIn(fastOscClk),
		.syncOut(),
		.risePulse(fastTick)
	);
	rlpc_sync u_lvSync (
		.clk(clk),
		.reset(reset),
		.asyncIn(lowVoltTrip),
		.syncOut(lowVoltSync),
		.risePulse()
	);

	rlpc_wakeup_timer #(
		.FAST_DIV(FAST_DIV)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.slowTick(slowTick),
		.fastTick(fastTick),
		.clockSelect(wakeClkSel_reg),
		.periodSelect(wakePeriod_reg),
		.timeout(timeout)
	);

	// address decode and write strobes
	assign selRti = (bus.addr == `RLPC_OFF_RTI);
	assign selPwr = (bus.addr == `RLPC_OFF_PWR);
	assign selPend = (bus.addr == `RLPC_OFF_PEND);
	assign wrRti = bus.wr && selRti;
	assign wrPwr = bus.wr && selPwr;
	assign wakeAck = wrRti && bus.wdata[`RLPC_RTI_ACK];
	assign lvAck = wrPwr && bus.wdata[`RLPC_PWR_ACK];

	// detection active, and in stop only with stop enable
	assign lowVoltDetectOn = lvLe_reg && (!stopMode || lvSe_reg);
	// level is sampled so a trip held across an ack re-sets the flag
	assign lvDetect = lowVoltDetectOn && lowVoltSync;

	// wakeup register: set wins over ack in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wakeFlag_reg <= 1'b0;
			wakeClkSel_reg <= 1'b0;
			wakeIe_reg <= 1'b0;
			wakePeriod_reg <= 3'h0;
		end else begin
			if (timeout)
				wakeFlag_reg <= 1'b1;
			else if (wakeAck)
				wakeFlag_reg <= 1'b0;
			if (wrRti) begin
				wakeClkSel_reg <= bus.wdata[`RLPC_RTI_CLKS];
				wakeIe_reg <= bus.wdata[`RLPC_RTI_IE];
				wakePeriod_reg <= bus.wdata[`RLPC_RTI_PER_HI:`RLPC_RTI_PER_LO];
			end
		end
	end

	// power register: read/write bits
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lvIe_reg <= 1'b0;
			lvSe_reg <= 1'b0;
			bandgap_buffer_enable_reg <= 1'b0;
		end else if (wrPwr) begin
			lvIe_reg <= bus.wdata[`RLPC_PWR_IE];
			lvSe_reg <= bus.wdata[`RLPC_PWR_SE];
			bandgap_buffer_enable_reg <= bus.wdata[`RLPC_PWR_BG];
		end
	end

	// write-once bits: first write locks them until reset
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lvRe_reg <= 1'b0;
			lvLe_reg <= 1'b0;
			lvOnceDone_reg <= 1'b0;
		end else if (wrPwr && !lvOnceDone_reg) begin
			lvRe_reg <= bus.wdata[`RLPC_PWR_RE];
			lvLe_reg <= bus.wdata[`RLPC_PWR_LE];
			lvOnceDone_reg <= 1'b1;
		end
	end

	// low-volt flag; disabling logic cannot occur after lock, so no clear
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			lvFlag_reg <= 1'b0;
		else if (lvDetect)
			lvFlag_reg <= 1'b1;
		else if (lvAck)
			lvFlag_reg <= 1'b0;
	end

	// requests, gated by their enables
	assign wakeupIrq = wakeFlag_reg && wakeIe_reg;
	assign lowVoltIrq = lvFlag_reg && lvIe_reg && lvLe_reg;
	assign lowVoltReset = lvFlag_reg && lvRe_reg && lvLe_reg;
	// slow oscillator off in stop only when both conditions hold
	assign slowOscPowerDown = stopMode && wakeClkSel_reg
		&& (wakePeriod_reg == 3'h0);
	assign bandgapBufferEnable = bandgap_buffer_enable_reg;

	// pending summary, live combination of flags and enables
	assign pendView = {3'h0,
		keypadSrc.flag & keypadSrc.enable,
		comparatorSrc.flag & comparatorSrc.enable,
		timerSrc.flag & timerSrc.enable,
		wakeupIrq,
		lowVoltIrq};
	assign pendingSummary = pendView;

	// read views; ack bits and unused bits read zero
	assign rtiView = {wakeFlag_reg, 1'b0, wakeClkSel_reg, wakeIe_reg,
		1'b0, wakePeriod_reg};
	assign pwrView = {lvFlag_reg, 1'b0, lvIe_reg, lvRe_reg, lvSe_reg,
		lvLe_reg, 1'b0, bandgap_buffer_enable_reg};

	// read mux; unmapped addresses and idle cycles return zero
	assign rdata_next = !bus.rd ? 8'h00 :
		selRti ? rtiView :
		selPwr ? pwrView :
		selPend ? pendView : 8'h00;

	// read data one cycle after the strobe
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end
	assign busRdata = rdata_reg;
endmodule : rlpc_ctrl

// ==== rtl/rlpc_regs.svh ====
`ifndef RLPC_REGS_SVH
`define RLPC_REGS_SVH

// register offsets
`define RLPC_OFF_RTI 8'h00
`define RLPC_OFF_PWR 8'h01
`define RLPC_OFF_PEND 8'h02

// wakeup timer register fields
`define RLPC_RTI_FLAG 7
`define RLPC_RTI_ACK 6
`define RLPC_RTI_CLKS 5
`define RLPC_RTI_IE 4
`define RLPC_RTI_PER_HI 2
`define RLPC_RTI_PER_LO 0

// power register fields
`define RLPC_PWR_FLAG 7
`define RLPC_PWR_ACK 6
`define RLPC_PWR_IE 5
`define RLPC_PWR_RE 4
`define RLPC_PWR_SE 3
`define RLPC_PWR_LE 2
`define RLPC_PWR_BG 0

// pending register fields
`define RLPC_PEND_KEY 4
`define RLPC_PEND_CMP 3
`define RLPC_PEND_TMR 2
`define RLPC_PEND_WAKE 1
`define RLPC_PEND_LV 0

// reset values
`define RLPC_RST_RTI 8'h00
`define RLPC_RST_PWR 8'h00

// timing: tick period in ms, fast clock divide
`define RLPC_TICK_MS 1
`define RLPC_FAST_DIV 32

// period table, in 1 ms ticks
`define RLPC_PER_1 11'd8
`define RLPC_PER_2 11'd32
`define RLPC_PER_3 11'd64
`define RLPC_PER_4 11'd128
`define RLPC_PER_5 11'd256
`define RLPC_PER_6 11'd512
`define RLPC_PER_7 11'd1024

`endif

// ==== rtl/rlpc_pkg.sv ====
package rlpc_pkg;

	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rlpc_bus_t;

	// flag and enable of one outside module
	typedef struct packed {
		logic flag;
		logic enable;
	} rlpc_src_t;

endpackage : rlpc_pkg

// ==== rtl/rlpc_sync.sv ====
`timescale 1ns/1ps

// two-stage synchroniser plus rising-edge pulse
module rlpc_sync (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// async level in, synced level and edge out
	input wire logic asyncIn,
	output logic syncOut,
	output logic risePulse
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// only sync_reg reads the first stage
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= asyncIn;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign syncOut = sync_reg;
	assign risePulse = sync_reg & ~last_reg;
endmodule : rlpc_sync

// ==== rtl/rlpc_wakeup_timer.sv ====
`timescale 1ns/1ps
`include "rlpc_regs.svh"

// periodic wakeup counter on 1 ms tick enables
module rlpc_wakeup_timer #(
	parameter int FAST_DIV = `RLPC_FAST_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// tick sources, one-cycle pulses
	input wire logic slowTick,
	input wire logic fastTick,
	// control
	input wire logic clockSelect,
	input wire logic [2:0] periodSelect,
	// timeout pulse
	output logic timeout
);
	logic [4:0] div_reg;
	logic [4:0] div_next;
	logic [10:0] cnt_reg;
	logic [10:0] cnt_next;
	logic [10:0] limit;
	logic divWrap;
	logic tick;
	logic running;
	logic hit;

	// period decode; 000 stops the timer
	always_comb begin
		case (periodSelect)
			3'h1: limit = `RLPC_PER_1;
			3'h2: limit = `RLPC_PER_2;
			3'h3: limit = `RLPC_PER_3;
			3'h4: limit = `RLPC_PER_4;
			3'h5: limit = `RLPC_PER_5;
			3'h6: limit = `RLPC_PER_6;
			3'h7: limit = `RLPC_PER_7;
			default: limit = 11'h000;
		endcase
	end

	// fast source divided to 1 kHz; select picks tick
	assign divWrap = fastTick && (div_reg == 5'(FAST_DIV - 1));
	assign div_next = divWrap ? 5'h00 : div_reg + 5'h01;
	assign tick = clockSelect ? divWrap : slowTick;
	assign running = (periodSelect != 3'h0);
	// period in ticks of 1 ms each
	assign hit = running && tick && (cnt_reg == limit - 11'h001);
	assign cnt_next = hit ? 11'h000 : cnt_reg + 11'h001;
	assign timeout = hit;

	// counter clears when stopped so next start is a full period
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			div_reg <= 5'h00;
			cnt_reg <= 11'h000;
		end else begin
			if (fastTick)
				div_reg <= div_next;
			if (!running)
				cnt_reg <= 11'h000;
			else if (tick)
				cnt_reg <= cnt_next;
		end
	end
endmodule : rlpc_wakeup_timer

// ==== test/rlpc_osc_model.sv ====
`timescale 1ns/1ps

// slow and trimmed oscillators, scaled down to a few clocks per phase
module rlpc_osc_model #(
	parameter int SLOW_HALF = 12,
	parameter int FAST_HALF = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// power down request from the block
	input wire logic powerDown,
	// oscillator levels
	output logic slowOscClk,
	output logic fastOscClk
);
	int sCnt;
	int fCnt;

	// slow one stops dead while powered down
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sCnt <= 0;
			slowOscClk <= 1'b0;
		end else if (powerDown) begin
			sCnt <= 0;
			slowOscClk <= 1'b0;
		end else if (sCnt == SLOW_HALF - 1) begin
			sCnt <= 0;
			slowOscClk <= !slowOscClk;
		end else begin
			sCnt <= sCnt + 1;
		end
	end

	// trimmed clock runs free
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			fCnt <= 0;
			fastOscClk <= 1'b0;
		end else begin
			fCnt <= (fCnt == FAST_HALF - 1) ? 0 : fCnt + 1;
			fastOscClk <= (fCnt == FAST_HALF - 1) ? !fastOscClk : fastOscClk;
		end
	end
endmodule : rlpc_osc_model

// ==== test/rlpc_ctrl_chk.sv ====
`timescale 1ns/1ps

module rlpc_ctrl_chk (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bus
	input wire logic [7:0] busAddr,
	input wire logic busRd,
	input wire logic [7:0] busRdata,
	// sources and outputs
	input wire logic stopMode,
	input wire rlpc_pkg::rlpc_src_t keypadSrc,
	input wire rlpc_pkg::rlpc_src_t comparatorSrc,
	input wire rlpc_pkg::rlpc_src_t timerSrc,
	input wire logic wakeupIrq,
	input wire logic lowVoltIrq,
	input wire logic slowOscPowerDown,
	input wire logic [7:0] pendingSummary
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	a_pend_key: assert property (
		pendingSummary[4] == (keypadSrc.flag & keypadSrc.enable))
		else $error("keypad pending wrong");
	a_pend_cmp: assert property (
		pendingSummary[3] == (comparatorSrc.flag & comparatorSrc.enable))
		else $error("comparator pending wrong");
	a_pend_tmr: assert property (
		pendingSummary[2] == (timerSrc.flag & timerSrc.enable))
		else $error("timer pending wrong");
	a_pend_wake: assert property (
		$past(busRd) && $past(busAddr) == 8'h00
		|-> $past(pendingSummary[1]) == (busRdata[7] & busRdata[4]))
		else $error("wakeup pending differs from flag and enable");
	a_pend_lv: assert property (
		$past(busRd) && $past(busAddr) == 8'h01
		|-> $past(pendingSummary[0])
		== (busRdata[7] & busRdata[5] & busRdata[2]))
		else $error("low volt pending differs from flag and enables");
	a_pend_unused: assert property (pendingSummary[7:5] == 3'h0)
		else $error("unused pending bits set");
	a_ack_reads: assert property (
		$past(busRd) && $past(busAddr) < 8'h02 |-> !busRdata[6])
		else $error("ack bit read as one");
	a_read_idle: assert property (!$past(busRd) |-> busRdata == 8'h00)
		else $error("read data outside read cycle");
	a_osc_down: assert property (slowOscPowerDown |-> stopMode)
		else $error("oscillator down outside stop");
endmodule : rlpc_ctrl_chk

bind rlpc_ctrl rlpc_ctrl_chk u_chk (.clk, .reset, .busAddr, .busRd,
	.busRdata, .stopMode, .keypadSrc, .comparatorSrc, .timerSrc,
	.wakeupIrq, .lowVoltIrq, .slowOscPowerDown, .pendingSummary);

// ==== test/rlpc_ctrl_test.sv ====
`timescale 1ns/1ps

module rlpc_ctrl_test;
	localparam int TK = 24; // clocks per scaled tick, both sources
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] busAddr = 8'h00;
	logic [7:0] busWdata = 8'h00;
	logic busWr = 1'b0;
	logic busRd = 1'b0;
	logic lowVoltTrip = 1'b0;
	logic stopMode = 1'b0;
	rlpc_pkg::rlpc_src_t keypadSrc = '0;
	rlpc_pkg::rlpc_src_t comparatorSrc = '0;
	rlpc_pkg::rlpc_src_t timerSrc = '0;
	logic [7:0] busRdata, pendingSummary;
	logic slowOscClk, fastOscClk, wakeupIrq, lowVoltIrq, lowVoltReset;
	logic lowVoltDetectOn, slowOscPowerDown, bandgapBufferEnable;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;

	// divider cut to 4 so a fast tick is 4 periods of 6 clocks
	rlpc_ctrl #(.FAST_DIV(4)) u_dut (.clk, .reset, .busAddr, .busWdata,
		.busWr, .busRd, .busRdata, .slowOscClk, .fastOscClk, .lowVoltTrip,
		.stopMode, .keypadSrc, .comparatorSrc, .timerSrc, .wakeupIrq,
		.lowVoltIrq, .lowVoltReset, .lowVoltDetectOn, .slowOscPowerDown,
		.bandgapBufferEnable, .pendingSummary);
	rlpc_osc_model u_osc (.clk, .reset, .powerDown(slowOscPowerDown),
		.slowOscClk, .fastOscClk);

	initial begin
		forever #12.5 clk = !clk;
	end

	// free cycle count, so timeout spacing can be checked exactly
	always @(posedge clk) cyc <= cyc + 1;

	task report_and_stop();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop

	task chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		busAddr <= a;
		busWdata <= d;
		busWr <= 1'b1;
		@(posedge clk);
		busWr <= 1'b0;
		#1;
	endtask : wr

	// data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		busAddr <= a;
		busRd <= 1'b1;
		@(posedge clk);
		busRd <= 1'b0;
		#1 chk(busRdata, exp);
	endtask : rd

	// every flag and enable pairing of the three outside sources
	task t_pend();
		logic [5:0] v;
		logic [7:0] e;
		rd(8'h02, 8'h00);
		for (int i = 0; i < 64; i++) begin
			v = i[5:0];
			e = {3'h0, &v[5:4], &v[3:2], &v[1:0], 2'h0};
			@(posedge clk);
			{keypadSrc, comparatorSrc, timerSrc} <= v;
			#1 chk(pendingSummary, e);
		end
		wr(8'h02, 8'hFF);
		rd(8'h02, 8'h1C);
		@(posedge clk);
		{keypadSrc, comparatorSrc, timerSrc} <= 6'h00;
	endtask : t_pend

	// timeout, gating and ack for one source and period
	task t_rti(input logic cs);
		int n;
		int t0;
		logic [7:0] d;
		n = cs ? 32 : 8;
		d = cs ? 8'h32 : 8'h11;
		wr(8'h00, 8'h00);
		wr(8'h00, d);
		repeat ((n - 1) * TK - 4) @(posedge clk);
		#1 chk(wakeupIrq, 1'b0);
		for (int i = 0; i < 2 * TK + 20 && wakeupIrq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		t0 = cyc;
		chk(wakeupIrq, 1'b1);
		rd(8'h00, 8'h80 | d);
		wr(8'h00, d & 8'hEF);
		chk(pendingSummary[1], 1'b0);
		rd(8'h00, 8'h80 | (d & 8'hEF));
		wr(8'h00, d | 8'h40);
		rd(8'h00, d);
		// ticks are periodic, so two timeouts lie exactly one period apart
		for (int i = 0; i < n * TK && wakeupIrq !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		chk(16'(cyc - t0), 16'(n * TK));
		wr(8'h00, 8'h40);
		rd(8'h00, 8'h00);
	endtask : t_rti

	// disabled timer, then oscillator power down in stop
	task t_off();
		wr(8'h00, 8'h10);
		@(posedge clk);
		stopMode <= 1'b1;
		repeat (12 * TK) @(posedge clk);
		#1 chk(wakeupIrq, 1'b0);
		chk(slowOscPowerDown, 1'b0);
		wr(8'h00, 8'h20);
		chk(slowOscPowerDown, 1'b1);
		wr(8'h00, 8'h21);
		chk(slowOscPowerDown, 1'b0);
		@(posedge clk);
		stopMode <= 1'b0;
	endtask : t_off

	// low voltage flag, outputs, write-once bits and stop detection
	task t_lv();
		lowVoltTrip <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h01, 8'h00);
		chk(lowVoltReset, 1'b0);
		lowVoltTrip <= 1'b0;
		repeat (8) @(posedge clk);
		wr(8'h01, 8'h35);
		rd(8'h01, 8'h35);
		chk(bandgapBufferEnable, 1'b1);
		lowVoltTrip <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h01, 8'hB5);
		chk({lowVoltIrq, lowVoltReset}, 2'h3);
		chk(pendingSummary[0], 1'b1);
		lowVoltTrip <= 1'b0;
		repeat (8) @(posedge clk);
		wr(8'h01, 8'h75);
		rd(8'h01, 8'h35);
		chk(pendingSummary[0], 1'b0);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h14);
		wr(8'h01, 8'h08);
		stopMode <= 1'b1;
		@(posedge clk);
		#1 chk(lowVoltDetectOn, 1'b1);
		wr(8'h01, 8'h00);
		chk(lowVoltDetectOn, 1'b0);
		lowVoltTrip <= 1'b1;
		repeat (8) @(posedge clk);
		rd(8'h01, 8'h14);
		lowVoltTrip <= 1'b0;
		repeat (8) @(posedge clk);
		stopMode <= 1'b0;
	endtask : t_lv

	// mid-run reset clears every register and re-arms write-once bits
	task t_rst();
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		wr(8'h01, 8'h04);
		rd(8'h01, 8'h04);
	endtask : t_rst

	// main sequence
	initial begin
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		t_pend();
		t_rti(1'b0);
		t_rti(1'b1);
		t_off();
		t_lv();
		t_rst();
		report_and_stop();
	end

	// hang guard, several times the expected run
	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		report_and_stop();
	end
endmodule : rlpc_ctrl_test
